/* verif/ipr_regs_properties.sv */
// Purpose: Concurrent checks on the ports of the priority register bank.
// Assumes: Bound into ipr_regs; one clock domain.
// Notes: Read data of the I2C2, error and low-voltage registers is tied to the level outputs, so a misplaced field there fails.
`timescale 1ns/1ns
`default_nettype none
`include "ipr_params.svh"
module ipr_regs_checker
  import ipr_pkg::*;
#(
  parameter int unsigned NUM_SRC = `IPR_NUM_SRC
) (
  // Clock and bus
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [`IPR_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // Requests and levels
  input wire logic [NUM_SRC-1:0] src_req_in,
  input wire logic [NUM_SRC-1:0] src_req_out,
  input wire logic [NUM_SRC-1:0] src_enabled_out,
  input wire ipr_level_type i2c2_master_event_level_out,
  input wire ipr_level_type i2c2_slave_event_level_out,
  input wire ipr_level_type checksum_error_level_out,
  input wire ipr_level_type serial2_error_level_out,
  input wire ipr_level_type serial1_error_level_out,
  input wire ipr_level_type low_voltage_level_out
);
  ////////////////////////////////////////
  wire ipr_level_type m = i2c2_master_event_level_out;
  wire ipr_level_type s = i2c2_slave_event_level_out;
  wire ipr_level_type c = checksum_error_level_out;
  wire ipr_level_type u2 = serial2_error_level_out;
  wire ipr_level_type u1 = serial1_error_level_out;
  wire ipr_level_type v = low_voltage_level_out;
  wire logic rd = pready_out && !pwrite_in;
  wire logic mapped = paddr_in[1:0] == 2'h0 && paddr_in <= `IPR_OFF_CHARGE;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  access_answer_a: assert property (psel_in && penable_in && !pready_out
    |=> pready_out ##1 !pready_out) else $error("bus answer not a single pulse");
  upper_zero_a: assert property (
    pready_out |-> prdata_out[31:16] == 16'h0000) else $error("upper read bits set");
  unmapped_a: assert property (
    pready_out && !mapped |-> pslverr_out && prdata_out == 32'h0)
    else $error("unmapped access not refused");
  i2c2_read_a: assert property (
    rd && paddr_in == `IPR_OFF_I2C2 |-> prdata_out[15:0] == {5'h00, m, 1'b0, s, 4'h0})
    else $error("i2c2 register layout wrong");
  error_read_a: assert property (
    rd && paddr_in == `IPR_OFF_ERROR |-> prdata_out[15:0] == {1'b0, c, 1'b0, u2, 1'b0, u1, 4'h0})
    else $error("error register layout wrong");
  lowvolt_read_a: assert property (
    rd && paddr_in == `IPR_OFF_LOWVOLT |-> prdata_out[15:0] == {13'h0000, v})
    else $error("low voltage register layout wrong");
  enable_flag_a: assert property (
    {src_enabled_out[8:5], src_enabled_out[1:0]} == {|v, |u1, |u2, |c, |s, |m})
    else $error("enable flag disagrees with level");
  req_gate_a: assert property (
    $past(rst_n_in) |-> src_req_out == $past(src_req_in & src_enabled_out))
    else $error("request gating wrong");
  reset_level_a: assert property (
    $rose(rst_n_in) |-> m == `IPR_LEVEL_RESET && c == `IPR_LEVEL_RESET && v == `IPR_LEVEL_RESET)
    else $error("level not four after reset");
  hold_level_a: assert property (
    !(pready_out && pwrite_in) |=> $stable({m, s, c, u2, u1, v}))
    else $error("level changed without a write");
  err_seen_c: cover property (pslverr_out);
  gate_block_c: cover property (src_req_in[0] && !src_enabled_out[0]);
  top_level_c: cover property (rd && prdata_out[14:12] == 3'h7);
endmodule
bind ipr_regs ipr_regs_checker #(.NUM_SRC(NUM_SRC)) ipr_regs_checker_i (.*);
`default_nettype wire

/* verif/tb_top.sv */
// Purpose: Self-checking bench for the priority register bank.
// Assumes: APB answers within a few cycles; one 20 MHz clock.
// Notes: Expected images are the field-LSB masks times the level.
`timescale 1ns/1ns
`default_nettype none
`include "ipr_params.svh"
module tb_top
  import ipr_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, pready_out, pslverr_out, e;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, r;
  logic [3:0] pstrb_in = 4'h0;
  logic [9:0] src_req_in = 10'h000, src_req_out, src_enabled_out;
  ipr_level_type lv [10];
  int n_errors = 0, n_compared = 0;
  // Bit set at the LSB of every field, one entry per register.
  logic [15:0] lsb [6] = '{16'h0110, 16'h0110, 16'h0100, 16'h1110, 16'h0001, 16'h0010};
  always #25 clk_in = ~clk_in;
  ipr_regs ipr_regs_i (.clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .pstrb_in, .prdata_out, .pready_out, .pslverr_out, .src_req_in, .src_req_out,
    .src_enabled_out, .i2c2_master_event_level_out(lv[0]), .i2c2_slave_event_level_out(lv[1]),
    .ext_irq4_level_out(lv[2]), .ext_irq3_level_out(lv[3]), .calendar_clock_level_out(lv[4]),
    .checksum_error_level_out(lv[5]), .serial2_error_level_out(lv[6]),
    .serial1_error_level_out(lv[7]), .low_voltage_level_out(lv[8]),
    .charge_timer_level_out(lv[9]));
  ////////////////////////////////////////
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Pready and read data are taken at the rising edge itself, before that edge's updates land.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    pstrb_in <= s;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (n > 20) begin
        n_errors++;
        test_done();
      end
    end while (pready_out !== 1'b1);
    r = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic t_reset();
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0, 4'h0);
      chk("reset image", r, {16'h0, lsb[i]} * 32'h4);
    end
    chk("reset enables", 32'(src_enabled_out), 32'h3FF);
    $display("t_reset done");
  endtask
  task automatic t_fields();
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 8'(i * 4), 32'hFFFF_FFFF, 4'hF);
    end
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0, 4'h0);
      chk("all ones image", r, {16'h0, lsb[i]} * 32'h7);
    end
    for (int k = 0; k < 10; k++) begin
      chk("level out", 32'(lv[k]), 32'h7);
    end
    $display("t_fields done");
  endtask
  task automatic t_levels();
    for (int v = 0; v < 8; v++) begin
      apb(1'b1, `IPR_OFF_ERROR, {16'h0, lsb[3]} * v, 4'hF);
      apb(1'b0, `IPR_OFF_ERROR, 32'h0, 4'h0);
      chk("error image", r, {16'h0, lsb[3]} * v);
      chk("checksum level", 32'(lv[5]), v);
      chk("error enables", 32'(src_enabled_out[7:5]), (v != 0) ? 32'h7 : 32'h0);
    end
    $display("t_levels done");
  endtask
  task automatic t_gate();
    apb(1'b1, `IPR_OFF_I2C2, 32'h0000_0030, 4'hF);
    src_req_in <= 10'h3FF;
    @(negedge clk_in);
    chk("req before edge", 32'(src_req_out), 32'h0);
    @(negedge clk_in);
    chk("gated req", 32'(src_req_out), 32'h3FE);
    @(posedge clk_in);
    src_req_in <= 10'h000;
    $display("t_gate done");
  endtask
  task automatic t_refuse();
    apb(1'b1, `IPR_OFF_ERROR, 32'h0, 4'h1);
    apb(1'b0, `IPR_OFF_ERROR, 32'h0, 4'h0);
    chk("lane0 only", r, 32'h7700);
    apb(1'b1, `IPR_OFF_LOWVOLT, 32'hFFFF_FFF8, 4'hF);
    apb(1'b0, `IPR_OFF_LOWVOLT, 32'h0, 4'h0);
    chk("low voltage off", r, 32'h0);
    chk("low voltage enable", 32'(src_enabled_out[8]), 32'h0);
    apb(1'b1, 8'h18, 32'hFFFF_FFFF, 4'hF);
    chk("unmapped write err", 32'(e), 32'h1);
    apb(1'b0, 8'h18, 32'h0, 4'h0);
    chk("unmapped read", r, 32'h0);
    chk("unmapped read err", 32'(e), 32'h1);
    $display("t_refuse done");
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_fields();
    t_levels();
    t_gate();
    t_refuse();
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    test_done();
  end
endmodule
`default_nettype wire

/* verilog/ipr_field.sv */
// Purpose: One three-bit interrupt priority field with its enable flag.
// Assumes: Write enable and data come from logic on the same clock.
// Notes: The enable flag is kept in its own flop so that it is a clean register output.
`timescale 1ns/1ns
`default_nettype none
`include "ipr_params.svh"

module ipr_field
  import ipr_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Write port
  input wire logic wr_en_in,
  input wire ipr_level_type wr_level_in,
  // Stored state
  output var ipr_level_type level_out,
  output var logic enabled_out
);

  ipr_level_type level_q;
  logic enabled_q;
  logic enabled_d;

  // A level of zero switches the source off; every other value is its priority.
  assign enabled_d = (wr_level_in != `IPR_LEVEL_OFF); // RL3

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      level_q <= `IPR_LEVEL_RESET; // RL5
      enabled_q <= 1'b1;
    end else if (wr_en_in) begin
      level_q <= wr_level_in; // RL1 RL2
      enabled_q <= enabled_d;
    end
  end

  assign level_out = level_q; // RL12
  assign enabled_out = enabled_q;

endmodule
`default_nettype wire

/* verilog/ipr_gate.sv */
// Purpose: Passes each source request on only while its priority field is nonzero.
// Assumes: Requests come from logic on the same clock; no synchroniser needed.
// Notes: One cycle of latency, traded for an output taken straight from a flop.
`timescale 1ns/1ns
`default_nettype none
`include "ipr_params.svh"

module ipr_gate #(
  parameter int unsigned NUM_SRC = `IPR_NUM_SRC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Raw requests and enables
  input wire logic [NUM_SRC-1:0] req_in,
  input wire logic [NUM_SRC-1:0] enabled_in,
  // Gated requests
  output var logic [NUM_SRC-1:0] req_out
);

  logic [NUM_SRC-1:0] req_q;

  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        req_q[i] <= 1'b0;
      end else begin
        req_q[i] <= req_in[i] & enabled_in[i]; // RL3
      end
    end
  end

  assign req_out = req_q;

endmodule
`default_nettype wire

/* verilog/ipr_params.svh */
// Purpose: Offsets, field positions, reset values and counts of the priority register bank.
// Assumes: APB byte addresses, one aligned 32-bit word per 16-bit register.
// Notes: Definitions only; included by its bare name.
`ifndef IPR_PARAMS_SVH
`define IPR_PARAMS_SVH

// Address width seen by the bank and the register byte offsets.
`define IPR_ADDR_W 8
`define IPR_OFF_I2C2 8'h00
`define IPR_OFF_EXTIRQ 8'h04
`define IPR_OFF_CALENDAR 8'h08
`define IPR_OFF_ERROR 8'h0C
`define IPR_OFF_LOWVOLT 8'h10
`define IPR_OFF_CHARGE 8'h14
`define IPR_NUM_REG 6

// Least significant bit of each three-bit priority field.
`define IPR_POS_I2C2_MASTER 8
`define IPR_POS_I2C2_SLAVE 4
`define IPR_POS_EXT_IRQ4 8
`define IPR_POS_EXT_IRQ3 4
`define IPR_POS_CALENDAR 8
`define IPR_POS_CHECKSUM 12
`define IPR_POS_SERIAL2 8
`define IPR_POS_SERIAL1 4
`define IPR_POS_LOW_VOLTAGE 0
`define IPR_POS_CHARGE_TIMER 4

// Field values and counts.
`define IPR_LEVEL_W 3
`define IPR_LEVEL_RESET 3'h4
`define IPR_LEVEL_OFF 3'h0
`define IPR_LEVEL_TOP 3'h7
`define IPR_NUM_SRC 10
`define IPR_LANE_W 8

`endif

/* verilog/ipr_pkg.sv */
// Purpose: Types shared by the priority register bank.
// Assumes: Nothing beyond the parameter header.
// Notes: Source order matches the field tables of the top module.
package ipr_pkg;

  typedef logic [2:0] ipr_level_type;

  typedef enum logic [3:0] {
    IPR_SRC_I2C2_MASTER = 4'h0,
    IPR_SRC_I2C2_SLAVE = 4'h1,
    IPR_SRC_EXT_IRQ4 = 4'h2,
    IPR_SRC_EXT_IRQ3 = 4'h3,
    IPR_SRC_CALENDAR = 4'h4,
    IPR_SRC_CHECKSUM = 4'h5,
    IPR_SRC_SERIAL2 = 4'h6,
    IPR_SRC_SERIAL1 = 4'h7,
    IPR_SRC_LOW_VOLTAGE = 4'h8,
    IPR_SRC_CHARGE_TIMER = 4'h9
  } ipr_src_type;

  typedef enum logic [1:0] {
    IPR_ST_IDLE = 2'b00,
    IPR_ST_READY = 2'b01
  } ipr_apb_state_type;

endpackage

/* verilog/ipr_regs.sv */
// Purpose: APB register bank of interrupt priority fields for ten sources.
// Assumes: APB master on clk_in; requests from sources on the same clock.
// Notes: Each 16-bit register sits in the low half of an aligned 32-bit word.
//
// Functional notes
// RL1 - Fields are three bits; value seven is the highest priority level.
// RL2 - Value one is the lowest enabled level; other values map directly.
// RL3 - A field of zero disables its source; its request never passes. The gate still passes a request for the one cycle after the zero is written.
// RL4 - Bits outside priority fields are unimplemented and read as zero.
// RL5 - After reset every field holds four: top bit set, lower bits clear.
// RL6 - I2C2 register: master event bits 10:8, slave event bits 6:4.
// RL7 - External register: interrupt four bits 10:8, interrupt three bits 6:4.
// RL8 - Calendar register: field at bits 10:8; bits 7:0 unimplemented.
// RL9 - Error register: checksum bits 14:12, serial2 bits 10:8, serial1 bits 6:4.
// RL10 - Low-voltage register: field at bits 2:0; bits 15:3 unimplemented.
// RL11 - Charge timer register: field at bits 6:4; all others unimplemented.
// RL12 - Writes to unimplemented bits are ignored; fields drive arbitration continuously.
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ipr_params.svh"

module ipr_regs
  import ipr_pkg::*;
#(
  parameter int unsigned NUM_SRC = `IPR_NUM_SRC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [`IPR_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output var logic [31:0] prdata_out,
  output var logic pready_out,
  output var logic pslverr_out,
  // Source requests and gated requests
  input wire logic [NUM_SRC-1:0] src_req_in,
  output var logic [NUM_SRC-1:0] src_req_out,
  output var logic [NUM_SRC-1:0] src_enabled_out,
  // Priority levels to the arbitration logic
  output var ipr_level_type i2c2_master_event_level_out,
  output var ipr_level_type i2c2_slave_event_level_out,
  output var ipr_level_type ext_irq4_level_out,
  output var ipr_level_type ext_irq3_level_out,
  output var ipr_level_type calendar_clock_level_out,
  output var ipr_level_type checksum_error_level_out,
  output var ipr_level_type serial2_error_level_out,
  output var ipr_level_type serial1_error_level_out,
  output var ipr_level_type low_voltage_level_out,
  output var ipr_level_type charge_timer_level_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Field layout tables, indexed by source number.

  localparam int unsigned NUM_REG = `IPR_NUM_REG;

  localparam int unsigned FIELD_POS [`IPR_NUM_SRC] = '{
    `IPR_POS_I2C2_MASTER, // RL6
    `IPR_POS_I2C2_SLAVE,
    `IPR_POS_EXT_IRQ4, // RL7
    `IPR_POS_EXT_IRQ3,
    `IPR_POS_CALENDAR, // RL8
    `IPR_POS_CHECKSUM, // RL9
    `IPR_POS_SERIAL2,
    `IPR_POS_SERIAL1,
    `IPR_POS_LOW_VOLTAGE, // RL10
    `IPR_POS_CHARGE_TIMER // RL11
  };

  // Register that holds each field, as an index into the decode vector.
  localparam int unsigned FIELD_REG [`IPR_NUM_SRC] = '{0, 0, 1, 1, 2, 3, 3, 3, 4, 5};

  // Places a level at its field position inside an otherwise zero half word.
  function automatic logic [15:0] place(input ipr_level_type lvl, input int unsigned pos);
    logic [15:0] word;
    word = {13'h0000, lvl};
    return word << pos;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode.

  logic hit_i2c2;
  logic hit_extirq;
  logic hit_calendar;
  logic hit_error;
  logic hit_lowvolt;
  logic hit_charge;
  logic [NUM_REG-1:0] reg_hit;
  logic addr_hit;

  assign hit_i2c2 = (paddr_in == `IPR_OFF_I2C2);
  assign hit_extirq = (paddr_in == `IPR_OFF_EXTIRQ);
  assign hit_calendar = (paddr_in == `IPR_OFF_CALENDAR);
  assign hit_error = (paddr_in == `IPR_OFF_ERROR);
  assign hit_lowvolt = (paddr_in == `IPR_OFF_LOWVOLT);
  assign hit_charge = (paddr_in == `IPR_OFF_CHARGE);
  assign reg_hit = {hit_charge, hit_lowvolt, hit_error, hit_calendar, hit_extirq, hit_i2c2};
  assign addr_hit = |reg_hit;

  ////////////////////////////////////////////////////////////////////////////////
  // APB handshake.
  // The first access cycle latches read data and raises pready; the write is
  // committed on the following edge, the one at which the master sees pready.

  ipr_apb_state_type state_q;
  ipr_apb_state_type state_d;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic access_first;
  logic access_done;
  logic commit;
  logic [31:0] rd_word;

  assign access_first = psel_in & penable_in & (state_q == IPR_ST_IDLE);
  assign access_done = psel_in & penable_in & (state_q == IPR_ST_READY);
  assign commit = access_done & pwrite_in & addr_hit;

  always_comb begin
    state_d = state_q;
    case (state_q)
      IPR_ST_IDLE: begin
        if (access_first) begin
          state_d = IPR_ST_READY;
        end
      end
      IPR_ST_READY: begin
        state_d = IPR_ST_IDLE;
      end
      default: begin
        state_d = IPR_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= IPR_ST_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      pready_q <= access_first;
      if (access_first) begin
        pslverr_q <= ~addr_hit;
        prdata_q <= pwrite_in ? 32'h0000_0000 : rd_word;
      end else begin
        pslverr_q <= 1'b0;
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign prdata_out = prdata_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Priority fields.
  // Only the three field bits are taken from the write data; every other
  // bit of a write has nowhere to go and is dropped.

  ipr_level_type lvl [`IPR_NUM_SRC];
  logic [NUM_SRC-1:0] enabled;

  for (genvar i = 0; i < `IPR_NUM_SRC; i++) begin : g_field
    logic wr_en;
    ipr_level_type wr_level;

    assign wr_en = commit & reg_hit[FIELD_REG[i]] & pstrb_in[FIELD_POS[i] / `IPR_LANE_W]; // RL12
    assign wr_level = pwdata_in[FIELD_POS[i] +: `IPR_LEVEL_W]; // RL12

    ipr_field u_field (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .wr_en_in(wr_en),
      .wr_level_in(wr_level),
      .level_out(lvl[i]),
      .enabled_out(enabled[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read words; unimplemented bits are zero in every register.

  logic [15:0] rd_i2c2;
  logic [15:0] rd_extirq;
  logic [15:0] rd_calendar;
  logic [15:0] rd_error;
  logic [15:0] rd_lowvolt;
  logic [15:0] rd_charge;
  logic [15:0] rd_half;

  assign rd_i2c2 = place(lvl[IPR_SRC_I2C2_MASTER], FIELD_POS[IPR_SRC_I2C2_MASTER])
                 | place(lvl[IPR_SRC_I2C2_SLAVE], FIELD_POS[IPR_SRC_I2C2_SLAVE]); // RL6
  assign rd_extirq = place(lvl[IPR_SRC_EXT_IRQ4], FIELD_POS[IPR_SRC_EXT_IRQ4])
                   | place(lvl[IPR_SRC_EXT_IRQ3], FIELD_POS[IPR_SRC_EXT_IRQ3]); // RL7
  assign rd_calendar = place(lvl[IPR_SRC_CALENDAR], FIELD_POS[IPR_SRC_CALENDAR]); // RL8
  assign rd_error = place(lvl[IPR_SRC_CHECKSUM], FIELD_POS[IPR_SRC_CHECKSUM])
                  | place(lvl[IPR_SRC_SERIAL2], FIELD_POS[IPR_SRC_SERIAL2])
                  | place(lvl[IPR_SRC_SERIAL1], FIELD_POS[IPR_SRC_SERIAL1]); // RL9
  assign rd_lowvolt = place(lvl[IPR_SRC_LOW_VOLTAGE], FIELD_POS[IPR_SRC_LOW_VOLTAGE]); // RL10
  assign rd_charge = place(lvl[IPR_SRC_CHARGE_TIMER], FIELD_POS[IPR_SRC_CHARGE_TIMER]); // RL11

  // Unmapped addresses read as zero and answer with pslverr.
  assign rd_half = hit_i2c2 ? rd_i2c2 :
                   hit_extirq ? rd_extirq :
                   hit_calendar ? rd_calendar :
                   hit_error ? rd_error :
                   hit_lowvolt ? rd_lowvolt :
                   hit_charge ? rd_charge : 16'h0000;
  assign rd_word = {16'h0000, rd_half}; // RL4

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs toward the arbitration logic, straight from the field flops.

  assign i2c2_master_event_level_out = lvl[IPR_SRC_I2C2_MASTER]; // RL12
  assign i2c2_slave_event_level_out = lvl[IPR_SRC_I2C2_SLAVE];
  assign ext_irq4_level_out = lvl[IPR_SRC_EXT_IRQ4];
  assign ext_irq3_level_out = lvl[IPR_SRC_EXT_IRQ3];
  assign calendar_clock_level_out = lvl[IPR_SRC_CALENDAR];
  assign checksum_error_level_out = lvl[IPR_SRC_CHECKSUM];
  assign serial2_error_level_out = lvl[IPR_SRC_SERIAL2];
  assign serial1_error_level_out = lvl[IPR_SRC_SERIAL1];
  assign low_voltage_level_out = lvl[IPR_SRC_LOW_VOLTAGE];
  assign charge_timer_level_out = lvl[IPR_SRC_CHARGE_TIMER];
  assign src_enabled_out = enabled;

  // A disabled source is cut off here; the arbiter still sees its request for the one cycle after its field is written to zero.
  ipr_gate #(
    .NUM_SRC(NUM_SRC)
  ) u_gate (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .req_in(src_req_in),
    .enabled_in(enabled),
    .req_out(src_req_out)
  );

endmodule
`default_nettype wire
